// >>> core/orc_pkg.sv
// Shared constants for the output relay conditioning block
package orc_pkg;
   // Bus register byte offsets
   localparam logic [5:0] ORC_OFS_CTRL = 6'h00;
   localparam logic [5:0] ORC_OFS_OFF_DELAY = 6'h04;
   localparam logic [5:0] ORC_OFS_HOLD_TIME = 6'h08;
   localparam logic [5:0] ORC_OFS_ACK_SEL = 6'h0C;
   localparam logic [5:0] ORC_OFS_STATUS = 6'h10;
   localparam logic [5:0] ORC_OFS_ASSIGN0 = 6'h20;
   // Field positions
   localparam int ORC_CTRL_LATCH_BIT = 0;
   localparam int ORC_CTRL_INV_BIT = 1;
   localparam int ORC_ASSIGN_INV_BIT = 8;
   localparam int ORC_SEL_W = 8;
   localparam int ORC_TIME_W = 15;
   // Reset values
   localparam logic [ORC_SEL_W-1:0] ORC_SEL_NONE = 8'h00;
   localparam logic [ORC_TIME_W-1:0] ORC_TIME_RESET = 15'h0000;
   // Timing: one setting step is 0.01 s
   localparam int ORC_TICK_NS = 10_000_000;
   localparam int ORC_CLK_PERIOD_NS = 50;
   localparam int ORC_TICK_CYCLES = ORC_TICK_NS / ORC_CLK_PERIOD_NS;
   localparam int ORC_TIME_MAX_S = 300;
   localparam int ORC_TIME_MAX_TICKS = ORC_TIME_MAX_S * 1000 / 10;
   // Relay sequencing states, Gray along idle-active-delay
   typedef enum logic [1:0] {
      ORC_ST_IDLE = 2'b00,
      ORC_ST_ACTIVE = 2'b01,
      ORC_ST_OFF_DELAY = 2'b11,
      ORC_ST_LATCHED = 2'b10
   } orc_state_type;
endpackage

// >>> core/orc_tick_timer.sv
// One-shot timer counting 10 ms ticks
`timescale 1ns/10ps
module orc_tick_timer import orc_pkg::*; #(
   parameter int TICK_CYCLES = ORC_TICK_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Control
   input wire logic start_i,
   input wire logic [ORC_TIME_W-1:0] length_i,
   // Status
   output logic busy_o
);
   logic [31:0] pre_r;
   logic [ORC_TIME_W-1:0] cnt_r;
   logic [ORC_TIME_W-1:0] len_r;

   // Length latched at start so later setting changes do not cut a run short
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         busy_o <= 1'b0;
         pre_r <= 32'h0000_0000;
         cnt_r <= ORC_TIME_RESET;
         len_r <= ORC_TIME_RESET;
      end else if (start_i) begin
         busy_o <= (length_i != ORC_TIME_RESET);
         pre_r <= 32'h0000_0000;
         cnt_r <= ORC_TIME_RESET;
         len_r <= length_i;
      end else if (busy_o) begin
         if (pre_r == 32'(TICK_CYCLES - 1)) begin
            pre_r <= 32'h0000_0000;
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == len_r - 1'b1) begin
               busy_o <= 1'b0; // Whole ticks only, never shorter
            end
         end else begin
            pre_r <= pre_r + 32'h0000_0001;
         end
      end
   end
endmodule

// >>> core/orc_relay.sv
// Output relay conditioning with Avalon-MM settings
`timescale 1ns/10ps
// Behaviour
// - Off delay keeps relay on, 0-300 s
// - Latching holds relay after pick-up
// - Selected acknowledge source releases latched relay
// - Acknowledge ignored unless latching enabled
// - Optional overall relay output inversion
// - Each slot selects source, own inversion
// - First slot defaults to protection alarm
// - Each new state held minimum hold time
module orc_relay import orc_pkg::*; #(
   parameter int NUM_SRC = 32,
   parameter int NUM_ASSIGN = 7,
   parameter int TICK_CYCLES = ORC_TICK_CYCLES,
   parameter bit IS_FIRST_RELAY_SLOT = 1'b1,
   parameter logic [ORC_SEL_W-1:0] ALARM_SEL = 8'h01
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Avalon-MM slave
   input wire logic [5:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   // Internal source signals, same clock
   input wire logic [NUM_SRC-1:0] src_i,
   // Relay coil drive
   output logic relay_o
);
   localparam logic [ORC_SEL_W-1:0] SEL0_RESET = IS_FIRST_RELAY_SLOT ? ALARM_SEL : ORC_SEL_NONE;

   logic latch_en_r;
   logic out_inv_r;
   logic [ORC_TIME_W-1:0] off_delay_r;
   logic [ORC_TIME_W-1:0] hold_time_r;
   logic [ORC_SEL_W-1:0] ack_sel_r;
   logic [ORC_SEL_W-1:0] sel_r [NUM_ASSIGN];
   logic [NUM_ASSIGN-1:0] sel_inv_r;
   orc_state_type state_r;
   orc_state_type state_nxt;
   logic held_r;
   logic wrote_any_r;
   logic combined;
   logic ack_level;
   logic pickup;
   logic off_start;
   logic off_busy;
   logic hold_start;
   logic hold_busy;
   logic bus_wr;

   // Selection 0 means unassigned; n picks source n-1
   function automatic logic src_pick(input logic [ORC_SEL_W-1:0] sel, input logic [NUM_SRC-1:0] src);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
         if (sel == ORC_SEL_W'(i + 1)) begin
            hit = src[i];
         end
      end
      return hit;
   endfunction

   // Settings above 300.00 s saturate rather than wrap
   function automatic logic [ORC_TIME_W-1:0] clamp_time(input logic [31:0] v);
      logic [ORC_TIME_W-1:0] res;
      res = (v > 32'(ORC_TIME_MAX_TICKS)) ? ORC_TIME_W'(ORC_TIME_MAX_TICKS) : v[ORC_TIME_W-1:0];
      return res;
   endfunction

   // Source combination
   always_comb begin
      combined = 1'b0;
      for (int k = 0; k < NUM_ASSIGN; k++) begin
         if (sel_r[k] != ORC_SEL_NONE) begin
            combined = combined | (src_pick(sel_r[k], src_i) ^ sel_inv_r[k]);
         end
      end
   end

   // Acknowledge only counts while latching is on
   assign ack_level = latch_en_r && (ack_sel_r != ORC_SEL_NONE) && src_pick(ack_sel_r, src_i);

   // Relay sequencing
   always_comb begin
      state_nxt = state_r;
      off_start = 1'b0;
      case (state_r)
         ORC_ST_IDLE: begin
            if (combined) begin
               state_nxt = ORC_ST_ACTIVE;
            end
         end
         ORC_ST_ACTIVE: begin
            if (!combined) begin
               if (latch_en_r && !ack_level) begin
                  state_nxt = ORC_ST_LATCHED;
               end else if (off_delay_r != ORC_TIME_RESET) begin
                  state_nxt = ORC_ST_OFF_DELAY;
                  off_start = 1'b1;
               end else begin
                  state_nxt = ORC_ST_IDLE;
               end
            end
         end
         ORC_ST_OFF_DELAY: begin
            if (combined) begin
               state_nxt = ORC_ST_ACTIVE;
            end else if (latch_en_r && !ack_level) begin
               state_nxt = ORC_ST_LATCHED;
            end else if (!off_busy) begin
               state_nxt = ORC_ST_IDLE;
            end
         end
         ORC_ST_LATCHED: begin
            // A live drive outranks an acknowledge
            if (combined) begin
               state_nxt = ORC_ST_LATCHED;
            end else if (!latch_en_r || ack_level) begin
               state_nxt = ORC_ST_IDLE;
            end
         end
         default: begin
            state_nxt = ORC_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_r <= ORC_ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign pickup = (state_r != ORC_ST_IDLE);
   assign hold_start = (pickup != held_r) && !hold_busy;

   // Held state changes only once the previous one served its hold time
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         held_r <= 1'b0;
      end else if (hold_start) begin
         held_r <= pickup;
      end
   end

   // Registered coil drive with overall inversion
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         relay_o <= 1'b0;
      end else begin
         relay_o <= held_r ^ out_inv_r;
      end
   end

   orc_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_off_timer (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .start_i(off_start),
      .length_i(off_delay_r),
      .busy_o(off_busy)
   );

   orc_tick_timer #(.TICK_CYCLES(TICK_CYCLES)) u_hold_timer (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .start_i(hold_start),
      .length_i(hold_time_r),
      .busy_o(hold_busy)
   );

   // Bus handshake: answer one cycle after a request, then release
   assign bus_wr = write_i && !waitrequest_o;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         waitrequest_o <= 1'b1;
      end else if ((read_i || write_i) && waitrequest_o) begin
         waitrequest_o <= 1'b0;
      end else begin
         waitrequest_o <= 1'b1;
      end
   end

   // Read data captured with the answer; unmapped reads give zero
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         readdata_o <= 32'h0000_0000;
      end else if (read_i && waitrequest_o) begin
         readdata_o <= 32'h0000_0000;
         if (address_i == ORC_OFS_CTRL) begin
            readdata_o[ORC_CTRL_LATCH_BIT] <= latch_en_r;
            readdata_o[ORC_CTRL_INV_BIT] <= out_inv_r;
         end else if (address_i == ORC_OFS_OFF_DELAY) begin
            readdata_o[ORC_TIME_W-1:0] <= off_delay_r;
         end else if (address_i == ORC_OFS_HOLD_TIME) begin
            readdata_o[ORC_TIME_W-1:0] <= hold_time_r;
         end else if (address_i == ORC_OFS_ACK_SEL) begin
            readdata_o[ORC_SEL_W-1:0] <= ack_sel_r;
         end else if (address_i == ORC_OFS_STATUS) begin
            readdata_o[6:0] <= {hold_busy, off_busy, state_r, combined, held_r, relay_o};
         end else begin
            for (int k = 0; k < NUM_ASSIGN; k++) begin
               if (address_i == ORC_OFS_ASSIGN0 + 6'(4 * k)) begin
                  readdata_o[ORC_SEL_W-1:0] <= sel_r[k];
                  readdata_o[ORC_ASSIGN_INV_BIT] <= sel_inv_r[k];
               end
            end
         end
      end
   end

   // Settings, written only at the answering edge
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         latch_en_r <= 1'b0;
         out_inv_r <= 1'b0;
         off_delay_r <= ORC_TIME_RESET;
         hold_time_r <= ORC_TIME_RESET;
         ack_sel_r <= ORC_SEL_NONE;
         wrote_any_r <= 1'b0;
         sel_inv_r <= '0;
         for (int k = 0; k < NUM_ASSIGN; k++) begin
            sel_r[k] <= (k == 0) ? SEL0_RESET : ORC_SEL_NONE;
         end
      end else if (bus_wr) begin
         wrote_any_r <= 1'b1;
         if (address_i == ORC_OFS_CTRL) begin
            latch_en_r <= writedata_i[ORC_CTRL_LATCH_BIT];
            out_inv_r <= writedata_i[ORC_CTRL_INV_BIT];
         end else if (address_i == ORC_OFS_OFF_DELAY) begin
            off_delay_r <= clamp_time(writedata_i);
         end else if (address_i == ORC_OFS_HOLD_TIME) begin
            hold_time_r <= clamp_time(writedata_i);
         end else if (address_i == ORC_OFS_ACK_SEL) begin
            ack_sel_r <= writedata_i[ORC_SEL_W-1:0];
         end else begin
            for (int k = 0; k < NUM_ASSIGN; k++) begin
               if (address_i == ORC_OFS_ASSIGN0 + 6'(4 * k)) begin
                  sel_r[k] <= writedata_i[ORC_SEL_W-1:0];
                  sel_inv_r[k] <= writedata_i[ORC_ASSIGN_INV_BIT];
               end
            end
         end
      end
   end

   a_off_delay_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_r == ORC_ST_ACTIVE && !combined && !latch_en_r && off_delay_r != ORC_TIME_RESET)
      |=> (state_r == ORC_ST_OFF_DELAY && off_busy && pickup))
      else $error("off delay not started");
   a_latch_holds: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_r == ORC_ST_LATCHED && latch_en_r && !ack_level) |=> state_r == ORC_ST_LATCHED)
      else $error("latched relay dropped");
   a_ack_release: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (state_r == ORC_ST_LATCHED && ack_level && !combined) |=> state_r == ORC_ST_IDLE)
      else $error("acknowledge did not release");
   a_ack_no_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (!latch_en_r && state_r != ORC_ST_LATCHED) |=> state_r != ORC_ST_LATCHED)
      else $error("latched without latching enabled");
   a_out_invert: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      ##1 relay_o == ($past(held_r) ^ $past(out_inv_r)))
      else $error("relay output inversion wrong");
   a_slot0_drive: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (sel_r[0] != ORC_SEL_NONE && (src_pick(sel_r[0], src_i) ^ sel_inv_r[0])) |-> combined)
      else $error("slot source not combined");
   a_default_alarm: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !wrote_any_r |-> sel_r[0] == SEL0_RESET)
      else $error("first slot default wrong");
   a_hold_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (hold_start && hold_time_r != ORC_TIME_RESET) |=> (hold_busy && held_r == $past(pickup)))
      else $error("hold time not started");
   a_hold_stable: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hold_busy |=> $stable(held_r))
      else $error("state changed during hold");
   a_or_pickup: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (combined && state_r == ORC_ST_IDLE) |=> state_r == ORC_ST_ACTIVE ##2 relay_o != out_inv_r || hold_busy)
      else $error("drive did not pick up");
endmodule

// >>> test/orc_coil_model.sv
// Behavioural relay coil and contact at the coil drive
`timescale 1ns/10ps
module orc_coil_model (
   // Clock
   input wire logic clk_i,
   // Coil drive
   input wire logic coil_i,
   // Contact state and last energised length in cycles
   output logic contact_o,
   output int last_on_o
);
   int run_r = 0;
   // No bounce modelled, so any chatter shows up as short on runs
   assign contact_o = coil_i;
   // Length of each energised period, published when the coil drops
   always_ff @(posedge clk_i) begin
      if (coil_i === 1'b1) begin
         run_r <= run_r + 1;
      end else begin
         if (run_r != 0) begin
            last_on_o <= run_r;
         end
         run_r <= 0;
      end
   end
endmodule

// >>> test/test_orc_relay.sv
// Self-checking bench for the output relay conditioning block
`timescale 1ns/10ps
module test_orc_relay import orc_pkg::*; ;
   localparam int T = 4;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [5:0] address_i = 6'h00;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0000_0000;
   logic [31:0] src_i = 32'h0000_0000;
   logic [31:0] readdata_o;
   logic waitrequest_o;
   logic relay_o;
   logic contact;
   int last_on;
   int errors = 0;
   int checked = 0;
   logic [31:0] rd;

   // 20 MHz clock
   always #25 clk_i = ~clk_i;

   orc_relay #(.TICK_CYCLES(T)) i_orc_relay (.clk_i(clk_i), .reset_n_i(reset_n_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .src_i(src_i), .relay_o(relay_o));
   orc_coil_model i_orc_coil_model (.clk_i(clk_i), .coil_i(relay_o), .contact_o(contact), .last_on_o(last_on));

   // Verdict and end of run
   task test_done;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task hang(input string name);
      errors++;
      $display("ERROR %s expected answer seen timeout", name);
      test_done();
   endtask

   // One Avalon transfer; request held until waitrequest_o is seen low at a rising edge
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address_i <= a;
      writedata_i <= d;
      write_i <= wr;
      read_i <= ~wr;
      @(posedge clk_i);
      while (waitrequest_o !== 1'b0) begin
         n++;
         if (n > 50) hang("waitrequest_o");
         @(posedge clk_i);
      end
      // Answer edge: write lands and read data are taken here
      rd = readdata_o;
      write_i <= 1'b0;
      read_i <= 1'b0;
      // Idle cycle so a following call never reassigns in this time step
      @(posedge clk_i);
   endtask

   // Bounded wait for a relay level; reaching it counts as a match
   task wait_relay(input logic exp);
      int n;
      n = 0;
      @(negedge clk_i);
      while (relay_o !== exp) begin
         n++;
         if (n > 100) hang("relay_o");
         @(negedge clk_i);
      end
      checked++;
      @(posedge clk_i);
   endtask

   // One-cycle source pulse on src_i[0]
   task pulse;
      src_i <= 32'h0000_0001;
      @(posedge clk_i);
      src_i <= 32'h0000_0000;
   endtask

   task sc_reset;
      wait_relay(1'b0);
      bus(1'b0, ORC_OFS_ASSIGN0, 32'h0000_0000);
      chk("assign0", 32'h0000_0001, rd);
      bus(1'b0, ORC_OFS_ASSIGN0 + 6'h04, 32'h0000_0000);
      chk("assign1", 32'h0000_0000, rd);
      bus(1'b0, ORC_OFS_CTRL, 32'h0000_0000);
      chk("ctrl", 32'h0000_0000, rd);
      bus(1'b0, ORC_OFS_OFF_DELAY, 32'h0000_0000);
      chk("off_delay", 32'h0000_0000, rd);
      bus(1'b0, ORC_OFS_HOLD_TIME, 32'h0000_0000);
      chk("hold_time", 32'h0000_0000, rd);
      bus(1'b0, ORC_OFS_ACK_SEL, 32'h0000_0000);
      chk("ack_sel", 32'h0000_0000, rd);
      bus(1'b0, 6'h3C, 32'h0000_0000);
      chk("unmapped", 32'h0000_0000, rd);
   endtask

   task sc_path;
      src_i <= 32'h0000_0001;
      wait_relay(1'b1);
      chk("contact", 32'h0000_0001, {31'h0, contact});
      src_i <= 32'h0000_0000;
      wait_relay(1'b0);
      bus(1'b1, ORC_OFS_ASSIGN0 + 6'h04, 32'h0000_0102);
      wait_relay(1'b1);
      src_i <= 32'h0000_0002;
      wait_relay(1'b0);
      bus(1'b1, ORC_OFS_ASSIGN0 + 6'h04, 32'h0000_0000);
      src_i <= 32'h0000_0000;
   endtask

   task sc_invert;
      bus(1'b1, ORC_OFS_CTRL, 32'h0000_0002);
      wait_relay(1'b1);
      src_i <= 32'h0000_0001;
      wait_relay(1'b0);
      src_i <= 32'h0000_0000;
      bus(1'b1, ORC_OFS_CTRL, 32'h0000_0000);
      wait_relay(1'b0);
   endtask

   // Three ticks of off delay stretch a one-cycle pulse
   task sc_off_delay;
      bus(1'b1, ORC_OFS_OFF_DELAY, 32'h0000_0003);
      pulse();
      wait_relay(1'b1);
      wait_relay(1'b0);
      repeat (2) @(posedge clk_i);
      chk("off delay min", 32'h0000_0001, 32'(last_on >= 3 * T));
      chk("off delay max", 32'h0000_0001, 32'(last_on <= 3 * T + 8));
      bus(1'b1, ORC_OFS_OFF_DELAY, 32'h0000_7531);
      bus(1'b0, ORC_OFS_OFF_DELAY, 32'h0000_0000);
      chk("off delay top", 32'h0000_7530, rd);
      bus(1'b1, ORC_OFS_OFF_DELAY, 32'h0000_0000);
   endtask

   task sc_hold;
      bus(1'b1, ORC_OFS_HOLD_TIME, 32'h0000_0005);
      pulse();
      wait_relay(1'b1);
      wait_relay(1'b0);
      repeat (2) @(posedge clk_i);
      chk("hold min", 32'h0000_0001, 32'(last_on >= 5 * T));
      chk("hold max", 32'h0000_0001, 32'(last_on <= 5 * T + 8));
      bus(1'b1, ORC_OFS_HOLD_TIME, 32'h0000_0000);
      // The drop started a fresh hold, so a short pulse now must be swallowed
      pulse();
      repeat (4) @(posedge clk_i);
      chk("hold off", 32'h0000_0000, {31'h0, relay_o});
      // Let the running hold expire before the next scenario
      repeat (5 * T + 4) @(posedge clk_i);
   endtask

   // Acknowledge comes from src_i[2]
   task sc_latch;
      bus(1'b1, ORC_OFS_ACK_SEL, 32'h0000_0003);
      pulse();
      wait_relay(1'b1);
      wait_relay(1'b0);
      bus(1'b1, ORC_OFS_CTRL, 32'h0000_0001);
      pulse();
      wait_relay(1'b1);
      repeat (30) @(posedge clk_i);
      wait_relay(1'b1);
      src_i <= 32'h0000_0004;
      wait_relay(1'b0);
      src_i <= 32'h0000_0000;
      bus(1'b1, ORC_OFS_CTRL, 32'h0000_0000);
      bus(1'b1, ORC_OFS_ACK_SEL, 32'h0000_0000);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      sc_reset();
      sc_path();
      sc_invert();
      sc_off_delay();
      sc_hold();
      sc_latch();
      test_done();
   end
endmodule
